// File: verilog/adcsr_top.sv
// adcsr_top: control and serial read-out of a pin-configured converter.
// assumes filtered two's complement results arrive on the conv stream;
// the host clock on SCLK is a clock of its own and may stop between bursts.
`timescale 1ns/1ps
module adcsr_top #(
	parameter int HALF_DIV  = adcsr_pkg::HALF_DIV,   // cycles per half tick
	parameter int UPDATE_HT = adcsr_pkg::UPDATE_HT,  // half ticks per result
	parameter int LOCK_HT   = adcsr_pkg::LOCK_HT,    // half ticks of lock
	parameter int WIDTH     = adcsr_pkg::WORD_BITS,  // result width
	parameter int DEPTH     = adcsr_pkg::FIFO_DEPTH  // buffered results
) (
	input  wire logic             CLK,                   // core clock
	input  wire logic             RESET,                 // sync, high
	input  wire logic             CS_N,                  // chip select pin
	input  wire logic             MODE,                  // 0 master 1 slave
	input  wire logic             RANGE_SEL,             // range pin
	input  wire logic             CURRENT_ROUTE_SELECT,  // route pin
	input  wire logic             SCLK,                  // serial clock in
	output logic                  SCLK_DRV,              // serial clock out
	output logic                  SCLK_OE,               // clock pin driven
	output logic                  DOUT,                  // data/ready out
	output logic                  DOUT_OE,               // data pin driven
	input  wire logic             CONV_VALID,            // result offered
	input  wire logic [WIDTH-1:0] CONV_DATA,             // signed result
	output logic                  CONV_READY,            // buffer has room
	output adcsr_pkg::adcsr_cfg_t CFG,                   // analog setup
	output logic                  AWAKE                  // out of standby
);
	localparam int DW = $clog2(HALF_DIV);
	localparam int TW = $clog2(UPDATE_HT);
	localparam int BW = $clog2(WIDTH + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(HALF_DIV - 1);
	localparam logic [TW-1:0] T_LAST   = TW'(UPDATE_HT - 1);
	localparam logic [TW-1:0] G_AT     = TW'(UPDATE_HT - 1 -
		adcsr_pkg::GUARD_HT);
	localparam logic [TW-1:0] L_LAST   = TW'(LOCK_HT - 1);
	localparam logic [BW-1:0] B_ALL    = BW'(WIDTH);
	localparam logic [BW-1:0] B_MSB    = BW'(WIDTH - 1);
	localparam logic [1:0]    S_DONE   = 2'(adcsr_pkg::SETTLE_N);
	localparam adcsr_pkg::adcsr_state_t ST_OFF   = adcsr_pkg::ST_OFF;
	localparam adcsr_pkg::adcsr_state_t ST_LOCK  = adcsr_pkg::ST_LOCK;
	localparam adcsr_pkg::adcsr_state_t ST_CONV  = adcsr_pkg::ST_CONV;
	localparam adcsr_pkg::adcsr_state_t ST_READY = adcsr_pkg::ST_READY;
	localparam adcsr_pkg::adcsr_state_t ST_SHIFT = adcsr_pkg::ST_SHIFT;

	//****************************************************************
	// pin synchronisers
	//****************************************************************
	logic [4:0] pin_s;
	logic       cs_n_s, mode_s, range_s, route_s, done_s;
	logic       ldone_q;

	adcsr_sync #(
		.W    (5),
		.INIT (adcsr_pkg::SYNC_INIT)
	) u_sync (
		.clk (CLK),
		.rst (RESET),
		.d   ({CS_N, MODE, RANGE_SEL, CURRENT_ROUTE_SELECT, ldone_q}),
		.q   (pin_s)
	);
	assign {cs_n_s, mode_s, range_s, route_s, done_s} = pin_s;

	//****************************************************************
	// result buffer
	//****************************************************************
	logic             f_valid, pop, flush;
	logic [WIDTH-1:0] f_data;

	adcsr_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RESET),
		.flush     (flush),
		.in_valid  (CONV_VALID),
		.in_data   (CONV_DATA),
		.in_ready  (CONV_READY),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (pop)
	);

	//****************************************************************
	// conversion sequencer and master shifter
	//****************************************************************
	adcsr_pkg::adcsr_state_t st_q, st_d;
	logic [DW-1:0]    div_q, div_d;
	logic [TW-1:0]    tcnt_q, tcnt_d;
	logic [1:0]       wraps_q, wraps_d;
	logic [WIDTH-1:0] word_q, word_d;
	logic [BW-1:0]    bit_q, bit_d;
	logic             sclk_q, sclk_d, dout_q, dout_d;
	logic             lclr_q, lclr_d, doe_q, doe_d, soe_q, soe_d;
	logic             awake_q, awake_d;
	adcsr_pkg::adcsr_cfg_t cfg_q, cfg_d;
	logic             ht;

	always_comb begin
		st_d    = st_q;
		wraps_d = wraps_q;
		word_d  = word_q;
		bit_d   = bit_q;
		sclk_d  = sclk_q;
		dout_d  = dout_q;
		pop     = 1'b0;
		// half-crystal tick; the crystal period sets both rate and clock
		ht      = (div_q == DIV_LAST);
		div_d   = ht ? '0 : div_q + 1'b1;
		tcnt_d  = tcnt_q;
		if (ht)
			tcnt_d = (tcnt_q == T_LAST) ? '0 : tcnt_q + 1'b1;
		unique case (st_q)
		ST_OFF: begin
			div_d   = '0;
			tcnt_d  = '0;
			wraps_d = '0;
			if (!cs_n_s)
				st_d = ST_LOCK;
		end
		ST_LOCK: begin
			if (ht && tcnt_q == L_LAST) begin
				st_d   = ST_CONV;
				tcnt_d = '0;
			end
		end
		ST_CONV: begin
			if (ht && tcnt_q == T_LAST) begin
				pop = f_valid;
				if (wraps_q != S_DONE)
					wraps_d = wraps_q + 1'b1;
				// the first period's output is unsettled and dropped
				if (f_valid && wraps_q != 2'h0) begin
					word_d = {~f_data[WIDTH-1], f_data[WIDTH-2:0]};
					bit_d  = '0;
					st_d   = ST_READY;
				end
			end
		end
		ST_READY: begin
			if (ht && tcnt_q == G_AT)
				st_d = ST_CONV;
			else if (mode_s && done_s)
				st_d = ST_CONV;
			else if (!mode_s && ht) begin
				// a full half tick has passed since ready fell
				st_d   = ST_SHIFT;
				sclk_d = 1'b0;
				dout_d = word_q[B_MSB - bit_q];
				bit_d  = bit_q + 1'b1;
			end
		end
		ST_SHIFT: begin
			if (ht && tcnt_q == G_AT)
				st_d = ST_CONV;
			else if (ht && !sclk_q)
				sclk_d = 1'b1;
			else if (ht && bit_q == B_ALL)
				// last bit held half a tick past its rising edge
				st_d = ST_CONV;
			else if (ht) begin
				sclk_d = 1'b0;
				dout_d = word_q[B_MSB - bit_q];
				bit_d  = bit_q + 1'b1;
			end
		end
		endcase
		if (cs_n_s) begin
			st_d   = ST_OFF;
			word_d = '0;
		end
		if (st_d != ST_SHIFT) begin
			sclk_d = 1'b1;
			dout_d = (st_d != ST_READY);
		end
		lclr_d  = !(st_d == ST_READY && mode_s);
		doe_d   = (st_d != ST_OFF);
		soe_d   = (st_d != ST_OFF) && !mode_s;
		awake_d = (st_d != ST_OFF);
		cfg_d.gain_amplifier_x16 = !range_s;
		cfg_d.current_route_swap = route_s;
		flush   = (st_q == ST_OFF);
		if (RESET) begin
			st_d    = ST_OFF;
			div_d   = '0;
			tcnt_d  = '0;
			wraps_d = '0;
			word_d  = '0;
			bit_d   = '0;
			sclk_d  = 1'b1;
			dout_d  = 1'b1;
			lclr_d  = 1'b1;
			doe_d   = 1'b0;
			soe_d   = 1'b0;
			awake_d = 1'b0;
			cfg_d   = '0;
		end
	end

	always_ff @(posedge CLK) begin
		st_q    <= st_d;
		div_q   <= div_d;
		tcnt_q  <= tcnt_d;
		wraps_q <= wraps_d;
		word_q  <= word_d;
		bit_q   <= bit_d;
		sclk_q  <= sclk_d;
		dout_q  <= dout_d;
		lclr_q  <= lclr_d;
		doe_q   <= doe_d;
		soe_q   <= soe_d;
		awake_q <= awake_d;
		cfg_q   <= cfg_d;
	end

	//****************************************************************
	// slave shifter on the host clock
	//****************************************************************
	// word_q is only rewritten while lclr_q holds this side cleared,
	// so it is stable for every edge the host may give here
	logic [BW-1:0] lcnt_q, lcnt_d;
	logic          sdo_q, sdo_d, ldone_d;

	always_comb begin
		lcnt_d = lcnt_q;
		sdo_d  = sdo_q;
		if (lcnt_q != B_ALL) begin
			sdo_d  = word_q[B_MSB - lcnt_q];
			lcnt_d = lcnt_q + 1'b1;
		end
		// done on the rising edge so the last bit is sampled first
		ldone_d = (lcnt_q == B_ALL);
	end

	always_ff @(negedge SCLK or posedge lclr_q) begin
		if (lclr_q) begin
			lcnt_q <= '0;
			sdo_q  <= 1'b0;
		end else begin
			lcnt_q <= lcnt_d;
			sdo_q  <= sdo_d;
		end
	end

	always_ff @(posedge SCLK or posedge lclr_q) begin
		if (lclr_q)
			ldone_q <= 1'b0;
		else
			ldone_q <= ldone_d;
	end

	//****************************************************************
	// pins
	//****************************************************************
	assign SCLK_DRV = sclk_q;
	assign SCLK_OE  = soe_q;
	assign DOUT     = lclr_q ? dout_q : sdo_q;
	assign DOUT_OE  = doe_q;
	assign CFG      = cfg_q;
	assign AWAKE    = awake_q;

	//****************************************************************
	// assertions
	//****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	logic [DW:0] rdy_cnt_q;
	always_ff @(posedge CLK) begin
		if (st_q != ST_READY)
			rdy_cnt_q <= '0;
		else
			rdy_cnt_q <= rdy_cnt_q + 1'b1;
	end

	standby_hiz_a: assert property (cs_n_s |=> !DOUT_OE && !SCLK_OE)
		else $error("pins driven in standby");
	busy_high_a: assert property (st_q == ST_CONV |-> DOUT && SCLK_DRV)
		else $error("data/ready or clock low while busy");
	ready_low_a: assert property ($rose(st_q == ST_READY) |-> !DOUT)
		else $error("data/ready not low with a result");
	master_low_a: assert property (st_q == ST_READY && !mode_s
		&& st_d == ST_SHIFT |-> rdy_cnt_q >= (DW+1)'(HALF_DIV - 1)
		&& !DOUT)
		else $error("first clock edge too early");
	bit_count_a: assert property (st_q == ST_SHIFT && st_d == ST_CONV
		&& !cs_n_s && !(ht && tcnt_q == G_AT) |-> bit_q == B_ALL)
		else $error("master burst not 24 clocks");
	msb_first_a: assert property ($rose(st_q == ST_SHIFT)
		|-> DOUT == word_q[WIDTH-1] && !SCLK_DRV)
		else $error("first bit is not the msb");
	fall_edge_a: assert property (st_q == ST_SHIFT
		&& $past(st_q) == ST_SHIFT && $changed(DOUT) |-> $fell(SCLK_DRV))
		else $error("data changed off a falling edge");
	settle_a: assert property ($rose(st_q == ST_READY)
		|-> wraps_q == S_DONE)
		else $error("result before two update periods");
	guard_a: assert property (tcnt_q == T_LAST && st_q != ST_LOCK
		|-> st_q != ST_READY && st_q != ST_SHIFT)
		else $error("result exposed across an update");
	lock_a: assert property (st_q == ST_LOCK && st_d == ST_CONV
		|-> tcnt_q == L_LAST && !cs_n_s)
		else $error("conversion before lock");
	cfg_a: assert property (!$past(RESET) |-> CFG ==
		{!$past(range_s), $past(route_s)})
		else $error("analog setup not following pins");

	master_xfer_c: cover property (st_q == ST_SHIFT && st_d == ST_CONV);
	slave_read_c: cover property (st_q == ST_READY && mode_s && done_s);
	abort_c: cover property (st_q == ST_SHIFT && cs_n_s);
	stale_c: cover property (st_q == ST_READY && ht && tcnt_q == G_AT);
endmodule

// File: verilog/adcsr_pkg.sv
// adcsr_pkg: constants and types of the converter read-out block.
// assumes a 50 MHz core clock and a 32.768 kHz crystal time base.
// Operation
// - mode pin 0 makes the device serial clock master, 1 makes it slave
// - master drives serial clock, one period per crystal period
// - slave accepts host clock in one train or bursts, keeps bit position
// - select low: wait for pll lock, then convert continuously
// - select high: abort, float data and clock pins, drop the result
// - data/ready high while converting, low once a result is ready
// - unread result: data/ready goes high again before the next update
// - master holds data/ready low half a clock before first edge
// - data changes after falling edge, receiver samples on rising edge
// - route pin low: source one to output one; high swaps them
// - range pin 0 gives 160 mV range, 1 gives 2.56 V range
// - result rate is crystal over 69 times 8 times 3
// - first settled result comes two update periods after start
// - filter notches at 50 Hz and 60 Hz at the fixed rate
// - master sends 24 clocks per result, then idles clock high
// - results leave as offset binary
package adcsr_pkg;
	localparam int CLK_HZ     = 50_000_000;
	localparam int XTAL_HZ    = 32768;
	// half a crystal period in core cycles, rounded down
	localparam int HALF_DIV   = CLK_HZ / (2 * XTAL_HZ);
	localparam int DEC_A      = 69;
	localparam int DEC_B      = 8;
	localparam int DEC_C      = 3;
	// one result per DEC_A*DEC_B*DEC_C crystal periods, in half periods
	localparam int UPDATE_HT  = 2 * DEC_A * DEC_B * DEC_C;
	localparam int SETTLE_N   = 2;
	localparam int LOCK_HT    = 32;
	localparam int GUARD_HT   = 2;
	localparam int WORD_BITS  = 24;
	localparam int FIFO_DEPTH = 32;
	localparam logic [4:0] SYNC_INIT = 5'h10;

	typedef enum {ST_OFF, ST_LOCK, ST_CONV, ST_READY, ST_SHIFT} adcsr_state_t;

	typedef struct packed {
		logic gain_amplifier_x16;  // 1: 160 mV range
		logic current_route_swap;  // 1: sources cross over
	} adcsr_cfg_t;
endpackage

// File: verilog/adcsr_sync.sv
// adcsr_sync: two-flop synchroniser for a bundle of levels.
// assumes each bit is a level that holds for several core cycles.
`timescale 1ns/1ps
module adcsr_sync #(
	parameter int           W    = 5,  // bundle width
	parameter logic [W-1:0] INIT = '0  // value during reset
) (
	input  wire logic         clk,  // destination clock
	input  wire logic         rst,  // sync reset, high
	input  wire logic [W-1:0] d,    // asynchronous levels
	output logic      [W-1:0] q     // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = rst ? INIT : d;
		q_d    = rst ? INIT : meta_q;
	end

	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		q      <= q_d;
	end
endmodule

// File: verilog/adcsr_fifo.sv
// adcsr_fifo: result buffer with registered read data.
// assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module adcsr_fifo #(
	parameter int WIDTH = 24,  // word width
	parameter int DEPTH = 32   // words, power of two
) (
	input  wire logic             clk,        // clock
	input  wire logic             rst,        // sync reset, high
	input  wire logic             flush,      // drop all words
	input  wire logic             in_valid,   // word offered
	input  wire logic [WIDTH-1:0] in_data,    // offered word
	output logic                  in_ready,   // room for a word
	output logic                  out_valid,  // word available
	output logic      [WIDTH-1:0] out_data,   // available word
	input  wire logic             out_ready   // word taken
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [AW:0]      used;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
	logic             ov_d;
	logic [WIDTH-1:0] od_d;
	logic             push, load;

	always_comb begin
		used     = wp_q - rp_q + {{AW{1'b0}}, out_valid};
		// the output register counts as one of the DEPTH words
		in_ready = (used != FULL);
		push = in_valid && in_ready;
		// refill the output register whenever it is free or being taken
		load = (wp_q != rp_q) && (!out_valid || out_ready);
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = load ? rp_q + 1'b1 : rp_q;
		ov_d = load || (out_valid && !out_ready);
		od_d = load ? mem_q[rp_q[AW-1:0]] : out_data;
		if (rst || flush) begin
			wp_d = '0;
			rp_d = '0;
			ov_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_q[wp_q[AW-1:0]] <= in_data;
		wp_q      <= wp_d;
		rp_q      <= rp_d;
		out_valid <= ov_d;
		out_data  <= od_d;
	end
endmodule

// File: sim/adcsr_host.sv
// adcsr_host: host serial port facing the converter read-out pins.
// assumes lclk is a free link reference; the clock and data lines idle high.
`timescale 1ns/1ps
module adcsr_host (
	input  wire logic        lclk,      // link reference clock
	input  wire logic        en,        // host willing to read
	input  wire logic        sclk_drv,  // device clock drive
	input  wire logic        sclk_oe,   // device drives clock pin
	input  wire logic        dout,      // device data/ready drive
	input  wire logic        dout_oe,   // device drives data pin
	output logic             sclk,      // clock pin level
	output logic      [23:0] rx_word,   // last word received
	output logic             rx_done    // pulse per word
);
	logic        host_sclk;
	logic        dout_l;
	logic [23:0] sh;
	int          cnt;

	// a pull-up keeps data/ready high when undriven; the host drives the clock line when the device does not
	assign sclk   = sclk_oe ? sclk_drv : host_sclk;
	assign dout_l = dout_oe ? dout : 1'b1;

	initial begin
		host_sclk = 1'b1;
		rx_done   = 1'b0;
		rx_word   = '0;
		sh        = '0;
		cnt       = 0;
	end

	// ********************************
	// slave clock: 24 pulses, bursts of 8
	// ********************************
	always begin
		@(posedge lclk);
		// only a slave-mode device waits for the host clock
		if (en && dout_oe && !sclk_oe && !dout_l) begin
			for (int b = 0; b < 24; b++) begin
				@(negedge lclk) host_sclk <= 1'b0;
				@(posedge lclk) host_sclk <= 1'b1;
				// parked high between bursts: stalls the read
				if (b % 8 == 7)
					repeat (4) @(posedge lclk);
			end
			wait (dout_l == 1'b1 || !dout_oe);
		end
	end

	// bits are taken on the rising edge, in both modes
	always @(posedge sclk or negedge dout_oe) begin
		if (!dout_oe) begin
			cnt = 0;
		end else begin
			sh  = {sh[22:0], dout_l};
			cnt = cnt + 1;
			if (cnt == 24) begin
				cnt     = 0;
				rx_word = sh;
				rx_done = 1'b1;
				rx_done <= #5 1'b0;
			end
		end
	end
endmodule

// File: sim/adcsr_top_bench.sv
// adcsr_top_bench: self-checking bench of the converter read-out block.
// assumes shortened counts; results are checked as the host receives them.
`timescale 1ns/1ps
module adcsr_top_bench;
	localparam int HD  = 4;
	localparam int UHT = 200;
	localparam int LHT = 4;

	logic                  CLK, RESET, CS_N, MODE, RANGE_SEL;
	logic                  CURRENT_ROUTE_SELECT, CONV_VALID, host_en;
	logic [23:0]           CONV_DATA, rx_word, rnd;
	wire                   SCLK;
	logic                  SCLK_DRV, SCLK_OE, DOUT, DOUT_OE;
	logic                  CONV_READY, AWAKE, rx_done, drop_next;
	adcsr_pkg::adcsr_cfg_t CFG;
	logic [23:0]           exp_q[$];
	logic [23:0]           edge_v[4] = '{24'h0, 24'h800000, 24'h7fffff, 24'h0};
	int                    n_fail = 0;
	int                    samples_checked = 0;
	int                    n, c;
	time                   t0;

	adcsr_top #(.HALF_DIV(HD), .UPDATE_HT(UHT), .LOCK_HT(LHT)) dut_u (
		.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .MODE(MODE),
		.RANGE_SEL(RANGE_SEL), .CURRENT_ROUTE_SELECT(CURRENT_ROUTE_SELECT),
		.SCLK(SCLK), .SCLK_DRV(SCLK_DRV), .SCLK_OE(SCLK_OE), .DOUT(DOUT),
		.DOUT_OE(DOUT_OE), .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA),
		.CONV_READY(CONV_READY), .CFG(CFG), .AWAKE(AWAKE));

	logic lclk = 1'b0;
	// half period 125 ns keeps host pulses above the 100 ns minimum width
	always #125 lclk = ~lclk;
	adcsr_host host_u (.lclk(lclk), .en(host_en), .sclk_drv(SCLK_DRV),
		.sclk_oe(SCLK_OE), .dout(DOUT), .dout_oe(DOUT_OE), .sclk(SCLK),
		.rx_word(rx_word), .rx_done(rx_done));

	initial CLK = 1'b0;
	always #10 CLK = ~CLK;

	// ********************************
	// helpers
	// ********************************
	function automatic logic [23:0] lfsr(input logic [23:0] s);
		return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
	endfunction

	task automatic tick();
		@(posedge CLK);
		#2;
	endtask

	task automatic check(input string what, input logic [23:0] seen,
			input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// offers words while the buffer has room; the first after wake is lost
	task automatic fill(input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && CONV_READY === 1'b1) begin
			rnd        = lfsr(rnd);
			CONV_VALID = 1'b1;
			CONV_DATA  = (cnt >= 1 && cnt <= 3) ? edge_v[cnt] : rnd;
			if (drop_next)
				drop_next = 1'b0;
			else
				exp_q.push_back({~CONV_DATA[23], CONV_DATA[22:0]});
			cnt++;
			tick();
		end
		CONV_VALID = 1'b0;
	endtask

	task automatic wake();
		CS_N      = 1'b0;
		drop_next = 1'b1;
		repeat (4) tick();
		check("awake", {AWAKE, DOUT_OE, SCLK_OE, DOUT}, {2'b11, ~MODE, 1'b1});
	endtask

	task automatic wait_empty();
		while (exp_q.size() != 0)
			tick();
		repeat (5) tick();
	endtask

	// ********************************
	// result monitor
	// ********************************
	always @(posedge rx_done) begin
		if (exp_q.size() == 0)
			check("word", rx_word, 'x);
		else
			check("word", rx_word, exp_q.pop_front());
	end

	initial begin
		#1_500_000;
		n_fail++;
		end_of_test();
	end

	// ********************************
	// main sequence
	// ********************************
	initial begin
		{CS_N, MODE, RESET} = 3'b111;
		{RANGE_SEL, CURRENT_ROUTE_SELECT, CONV_VALID, host_en} = 4'h0;
		CONV_DATA = '0;
		rnd       = 24'h000004;
		drop_next = 1'b0;
		repeat (3) tick();
		check("reset", {SCLK_OE, DOUT_OE, AWAKE, SCLK_DRV, DOUT}, 5'b00011);
		tick();
		RESET = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{RANGE_SEL, CURRENT_ROUTE_SELECT} = i[1:0];
			repeat (4) tick();
			check("cfg", CFG, {22'h0, ~i[1], i[0]});
		end
		// slave: fill until refused, host drains in bursts
		wake();
		fill(40, n);
		check("fill", n, 32);
		check("full", CONV_READY, 0);
		host_en = 1'b1;
		wait_empty();
		c = 0;
		repeat (UHT * HD + 100) begin
			tick();
			c += (DOUT !== 1'b1);
		end
		check("empty idle", c, 0);
		// slave: an unread result is withdrawn before the next update
		host_en = 1'b0;
		fill(2, n);
		while (DOUT !== 1'b0)
			tick();
		c = 0;
		while (DOUT !== 1'b1) begin
			tick();
			c++;
		end
		check("unread", c < UHT * HD, 1);
		void'(exp_q.pop_front());
		host_en = 1'b1;
		wait_empty();
		// master: lead, clock period, rate, idle level, abort
		CS_N = 1'b1;
		repeat (4) tick();
		MODE = 1'b0;
		wake();
		fill(6, n);
		@(negedge DOUT) t0 = $time;
		@(negedge SCLK_DRV);
		check("lead", ($time - t0) >= HD * 20, 1);
		c = 24'($time);
		@(negedge SCLK_DRV);
		check("sclk period", 24'($time) - c[23:0], 2 * HD * 20);
		@(posedge rx_done);
		repeat (HD + 2) tick();
		check("idle", {SCLK_DRV, DOUT}, 2'b11);
		@(negedge DOUT);
		check("rate", 24'($time - t0), UHT * HD * 20);
		@(posedge rx_done);
		@(negedge DOUT);
		@(negedge SCLK_DRV);
		repeat (2) tick();
		CS_N = 1'b1;
		exp_q.delete();
		repeat (3) tick();
		check("abort", {SCLK_OE, DOUT_OE, AWAKE}, 3'b000);
		tick();
		wake();
		fill(3, n);
		wait_empty();
		end_of_test();
	end
endmodule
